// ===== pkg/pll_ctl_pkg.sv
// Shared constants for the PLL control and status slice.
`default_nettype none
package pll_ctl_pkg;
    // Register offsets on the serial control bus.
    localparam logic [7:0] OFS_OUT_DIV_LO = 8'h20;
    localparam logic [7:0] OFS_OUT_DIV_HI = 8'h21;
    localparam logic [7:0] OFS_REF_CTRL = 8'h22;
    localparam logic [7:0] OFS_FB_INT = 8'h23;
    localparam logic [7:0] OFS_NUM_2 = 8'h24;
    localparam logic [7:0] OFS_NUM_1 = 8'h25;
    localparam logic [7:0] OFS_NUM_0 = 8'h26;
    localparam logic [7:0] OFS_DEN_2 = 8'h27;
    localparam logic [7:0] OFS_DEN_1 = 8'h28;
    localparam logic [7:0] OFS_DEN_0 = 8'h29;
    localparam logic [7:0] OFS_PLL_LIVE_STATE = 8'h42;
    localparam logic [7:0] OFS_MODULE_SOFT_RESET = 8'h48;
    // Field positions.
    localparam int LIVE_UNLOCKED_BIT = 1;
    localparam int LIVE_CAL_BIT = 0;
    localparam int SOFT_RESET_PLL_BIT = 1;
    localparam int REF_PREDIV4_BIT = 0;
    localparam int REF_DOUBLER_BIT = 1;
    // Widths and limits.
    localparam int FRAC_W = 22;
    localparam int OUT_DIV_W = 9;
    localparam logic [8:0] OUT_DIV_MIN = 9'h005;
    localparam logic [8:0] OUT_DIV_MAX = 9'h1ff;
    // Reset values and the read-as-zero value.
    localparam logic [8:0] OUT_DIV_RESET = 9'h04c;
    localparam logic [7:0] FB_INT_RESET = 8'hdc;
    localparam logic [21:0] NUM_RESET = 22'h00_0000;
    localparam logic [21:0] DEN_RESET = 22'h3f_ffff;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Serial control bus target states.
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_WRITE, BUS_ACK_WRITE, BUS_READ, BUS_HOST_ACK
    } bus_state_t;
endpackage : pll_ctl_pkg
`default_nettype wire

// ===== rtl/serial_reg_target.sv
// Two-wire serial control bus target with a byte register pointer.
`timescale 1ns/1ps
`default_nettype none
module serial_reg_target #(
    parameter logic [6:0] DEV_ADDR = 7'h58
) (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [7:0] reg_ptr,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    typedef struct packed {
        pll_ctl_pkg::bus_state_t st;
        logic scl_q;
        logic sda_q;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [7:0] ptr;
        logic ptr_set;
        logic rw;
        logic drive;
        logic wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } bus_regs_t;

    bus_regs_t s;
    bus_regs_t next_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Addresses 0 to 7 are reserved on this bus and cannot be served.
    if (DEV_ADDR < 7'h08) begin : g_addr_check
        $error("DEV_ADDR lies in the reserved range");
    end

    // Bus edges, with pins taken as synchronous to clk_sys.
    assign scl_rise = scl_in & ~s.scl_q;
    assign scl_fall = ~scl_in & s.scl_q;
    assign start_seen = scl_in & s.scl_q & s.sda_q & ~sda_in;
    assign stop_seen = scl_in & s.scl_q & ~s.sda_q & sda_in;

    // Bits are sampled on the rising clock edge and driven after the falling one.
    always_comb begin
        next_s = s;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        next_s.wr_stb = 1'b0;
        if (start_seen) begin
            next_s.st = pll_ctl_pkg::BUS_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.drive = 1'b0;
        end else if (stop_seen) begin
            next_s.st = pll_ctl_pkg::BUS_IDLE;
            next_s.drive = 1'b0;
        end else begin
            case (s.st)
                pll_ctl_pkg::BUS_ADDR, pll_ctl_pkg::BUS_WRITE: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], sda_in};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == 4'h8) begin
                        if (s.st == pll_ctl_pkg::BUS_ADDR) begin
                            if (s.shift[7:1] == DEV_ADDR) begin
                                next_s.st = pll_ctl_pkg::BUS_ACK_ADDR;
                                next_s.drive = 1'b1;
                                next_s.rw = s.shift[0];
                                next_s.ptr_set = 1'b0;
                            end else begin
                                next_s.st = pll_ctl_pkg::BUS_IDLE;
                            end
                        end else begin
                            next_s.st = pll_ctl_pkg::BUS_ACK_WRITE;
                            next_s.drive = 1'b1;
                            if (!s.ptr_set) begin
                                next_s.ptr = s.shift;
                                next_s.ptr_set = 1'b1;
                            end else begin
                                next_s.wr_stb = 1'b1;
                                next_s.wr_addr = s.ptr;
                                next_s.wr_data = s.shift;
                                next_s.ptr = s.ptr + 8'h01;
                            end
                        end
                    end
                end
                pll_ctl_pkg::BUS_ACK_ADDR, pll_ctl_pkg::BUS_HOST_ACK: begin
                    if (s.st == pll_ctl_pkg::BUS_HOST_ACK && scl_rise && sda_in) begin
                        next_s.st = pll_ctl_pkg::BUS_IDLE; // Host refused more data.
                    end else if (scl_fall) begin
                        next_s.bitcnt = 4'h0;
                        if (s.rw) begin
                            next_s.st = pll_ctl_pkg::BUS_READ;
                            next_s.shift = rd_data;
                            next_s.drive = ~rd_data[7];
                        end else begin
                            next_s.st = pll_ctl_pkg::BUS_WRITE;
                            next_s.drive = 1'b0;
                        end
                    end
                end
                pll_ctl_pkg::BUS_ACK_WRITE: begin
                    if (scl_fall) begin
                        next_s.st = pll_ctl_pkg::BUS_WRITE;
                        next_s.drive = 1'b0;
                        next_s.bitcnt = 4'h0;
                    end
                end
                pll_ctl_pkg::BUS_READ: begin
                    if (scl_rise) begin
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s.bitcnt == 4'h8) begin
                            next_s.st = pll_ctl_pkg::BUS_HOST_ACK;
                            next_s.drive = 1'b0;
                            next_s.ptr = s.ptr + 8'h01;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.drive = ~s.shift[6];
                        end
                    end
                end
                default: begin
                    next_s.st = pll_ctl_pkg::BUS_IDLE;
                    next_s.drive = 1'b0;
                end
            endcase
        end
    end

    // The idle bus is high, so the edge history starts high.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '{st: pll_ctl_pkg::BUS_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0; // Open drain: only ever pulls low.
    assign sda_oe_n = ~s.drive;
    assign reg_ptr = s.ptr;
    assign wr_stb = s.wr_stb;
    assign wr_addr = s.wr_addr;
    assign wr_data = s.wr_data;
endmodule : serial_reg_target
`default_nettype wire

// ===== rtl/pll_status_reset_tuning.sv
// Control and status registers of a fractional-N PLL oscillator behind a serial bus.
//
// How it works
// R1: Live status register shows loss of lock at bit 1, calibration at bit 0.
// R2: Each soft reset bit clears itself after the write that set it.
// R3: Reading the soft reset register always returns zero.
// R4: Writing one to soft reset bit 1 restarts PLL calibrator and divider chain.
// R5: Output divider accepts ratios 5 to 511; host programs only that range.
// R6: Reference pre-divider is 1 or 4, then a doubler of one or two.
// R7: Host keeps output frequency times total division within 4.6 to 5.6 GHz.
// R8: Numerator rewrites take effect glitch-free; host keeps integer part unchanged.
// R9: Host keeps numerator between zero and the denominator during tuning.
// R10: PLL soft reset lasts one cycle; divider and calibrator restart from reset.
`timescale 1ns/1ps
`default_nettype none
module pll_status_reset_tuning #(
    parameter logic [6:0] DEV_ADDR = 7'h58 // Bus address value is arbitrary.
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic pll_unlocked,
    input wire logic pll_cal_active,
    output logic pll_soft_reset,
    output logic [8:0] out_div_ratio,
    output logic out_div_tick,
    output logic ref_prediv4,
    output logic ref_doubler,
    output logic [7:0] fb_int,
    output logic [21:0] fb_num,
    output logic [21:0] fb_den
);
    typedef struct packed {
        logic [1:0] live;
        logic soft_rst;
        logic [7:0] out_div_lo;
        logic [8:0] out_div;
        logic [8:0] div_cnt;
        logic div_tick;
        logic prediv4;
        logic doubler;
        logic [7:0] fb_int;
        logic [13:0] num_shadow;
        logic [21:0] num;
        logic [21:0] den;
    } pll_regs_t;

    pll_regs_t s;
    pll_regs_t next_s;
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic [7:0] reg_ptr;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [21:0] num_candidate;
    logic [8:0] div_candidate;

    // Reset is asserted at once and released after two clean clock edges.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    serial_reg_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bus (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .reg_ptr(reg_ptr),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    assign num_candidate = {s.num_shadow, wr_data};
    assign div_candidate = {wr_data[0], s.out_div_lo};

    // Read data for the byte the bus pointer addresses; unmapped bytes read zero.
    always_comb begin
        case (reg_ptr)
            pll_ctl_pkg::OFS_PLL_LIVE_STATE: rd_data = {6'h00, s.live}; // [R1]
            pll_ctl_pkg::OFS_MODULE_SOFT_RESET: rd_data = pll_ctl_pkg::READ_ZERO; // [R3]
            pll_ctl_pkg::OFS_OUT_DIV_LO: rd_data = s.out_div[7:0];
            pll_ctl_pkg::OFS_OUT_DIV_HI: rd_data = {7'h00, s.out_div[8]};
            pll_ctl_pkg::OFS_REF_CTRL: rd_data = {6'h00, s.doubler, s.prediv4};
            pll_ctl_pkg::OFS_FB_INT: rd_data = s.fb_int;
            pll_ctl_pkg::OFS_NUM_2: rd_data = {2'b00, s.num[21:16]};
            pll_ctl_pkg::OFS_NUM_1: rd_data = s.num[15:8];
            pll_ctl_pkg::OFS_NUM_0: rd_data = s.num[7:0];
            pll_ctl_pkg::OFS_DEN_2: rd_data = {2'b00, s.den[21:16]};
            pll_ctl_pkg::OFS_DEN_1: rd_data = s.den[15:8];
            pll_ctl_pkg::OFS_DEN_0: rd_data = s.den[7:0];
            default: rd_data = pll_ctl_pkg::READ_ZERO;
        endcase
    end

    // Next state: live status capture, output divider chain and register writes.
    always_comb begin
        next_s = s;
        next_s.live[pll_ctl_pkg::LIVE_UNLOCKED_BIT] = pll_unlocked; // [R1]
        next_s.live[pll_ctl_pkg::LIVE_CAL_BIT] = pll_cal_active; // [R1]
        next_s.soft_rst = 1'b0; // [R2]
        // Output divider counts clk_sys and emits one tick per programmed ratio.
        if (s.div_cnt == s.out_div - 9'h001) begin
            next_s.div_cnt = 9'h000;
            next_s.div_tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + 9'h001;
            next_s.div_tick = 1'b0;
        end
        if (wr_stb) begin
            case (wr_addr)
                pll_ctl_pkg::OFS_MODULE_SOFT_RESET: begin
                    next_s.soft_rst = wr_data[pll_ctl_pkg::SOFT_RESET_PLL_BIT]; // [R4] [R10]
                end
                pll_ctl_pkg::OFS_OUT_DIV_LO: next_s.out_div_lo = wr_data;
                pll_ctl_pkg::OFS_OUT_DIV_HI: begin
                    // Ratios below the minimum are dropped so the divider never stalls.
                    if (div_candidate >= pll_ctl_pkg::OUT_DIV_MIN && div_candidate <= pll_ctl_pkg::OUT_DIV_MAX) begin
                        next_s.out_div = div_candidate; // [R5]
                    end
                end
                pll_ctl_pkg::OFS_REF_CTRL: begin
                    next_s.prediv4 = wr_data[pll_ctl_pkg::REF_PREDIV4_BIT]; // [R6]
                    next_s.doubler = wr_data[pll_ctl_pkg::REF_DOUBLER_BIT]; // [R6]
                end
                pll_ctl_pkg::OFS_FB_INT: next_s.fb_int = wr_data;
                pll_ctl_pkg::OFS_NUM_2: next_s.num_shadow[13:8] = wr_data[5:0];
                pll_ctl_pkg::OFS_NUM_1: next_s.num_shadow[7:0] = wr_data;
                pll_ctl_pkg::OFS_NUM_0: begin
                    // The whole numerator moves in one step, so no torn value reaches the loop.
                    if (num_candidate <= s.den) begin
                        next_s.num = num_candidate; // [R8] [R9]
                    end
                end
                pll_ctl_pkg::OFS_DEN_2: next_s.den[21:16] = wr_data[5:0];
                pll_ctl_pkg::OFS_DEN_1: next_s.den[15:8] = wr_data;
                pll_ctl_pkg::OFS_DEN_0: next_s.den[7:0] = wr_data;
                default: begin
                end
            endcase
        end
        // The cycle of the reset pulse restarts the divider chain from zero.
        if (s.soft_rst) begin
            next_s.div_cnt = 9'h000; // [R4] [R10]
            next_s.div_tick = 1'b0;
        end
    end

    // One register for the whole state.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '{out_div: pll_ctl_pkg::OUT_DIV_RESET, fb_int: pll_ctl_pkg::FB_INT_RESET,
                   num: pll_ctl_pkg::NUM_RESET, den: pll_ctl_pkg::DEN_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign pll_soft_reset = s.soft_rst; // [R10]
    assign out_div_ratio = s.out_div;
    assign out_div_tick = s.div_tick;
    assign ref_prediv4 = s.prediv4;
    assign ref_doubler = s.doubler;
    assign fb_int = s.fb_int;
    assign fb_num = s.num;
    assign fb_den = s.den;
endmodule : pll_status_reset_tuning
`default_nettype wire

// ===== verification/pll_status_reset_tuning_asserts.sv
// Checker of the PLL control slice outputs, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pll_ctl_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic pll_unlocked,
    input wire logic pll_cal_active,
    input wire logic pll_soft_reset,
    input wire logic [8:0] out_div_ratio,
    input wire logic out_div_tick,
    input wire logic ref_prediv4,
    input wire logic ref_doubler,
    input wire logic [7:0] fb_int,
    input wire logic [21:0] fb_num,
    input wire logic [21:0] fb_den
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [8:0] gap, last_ratio;
    logic gap_ok;
    // A tick gap is judged only after a full period under one ratio, since a ratio change leaves the count running.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 9'h000;
            last_ratio <= 9'h000;
            gap_ok <= 1'b0;
        end else begin
            last_ratio <= out_div_ratio;
            gap <= out_div_tick ? 9'h000 : gap + 9'h001;
            if (pll_soft_reset || out_div_ratio != last_ratio) begin
                gap_ok <= 1'b0;
            end else if (out_div_tick) begin
                gap_ok <= 1'b1;
            end
        end
    end
    soft_pulse_a: assert property (pll_soft_reset |=> !pll_soft_reset)
        else $error("soft reset pulse too long");
    soft_cause_a: assert property (pll_soft_reset |-> $past(sda_oe_n) == 1'b0)
        else $error("soft reset without a write");
    tick_hold_a: assert property (pll_soft_reset |=> !out_div_tick [*4])
        else $error("divider not restarted");
    tick_gap_a: assert property (out_div_tick && gap_ok && out_div_ratio == last_ratio
        |-> gap == out_div_ratio - 9'h001) else $error("tick spacing wrong");
    ratio_range_a: assert property ($changed(out_div_ratio) |-> out_div_ratio >= 9'h005)
        else $error("divider ratio below range");
    num_bound_a: assert property ($changed(fb_num) |-> fb_num <= fb_den)
        else $error("numerator above denominator");
    num_tune_a: assert property ($changed(fb_num) |-> $stable(fb_int) && $stable(out_div_ratio))
        else $error("tuning disturbed the integer part");
    write_cause_a: assert property ($changed({ref_doubler, ref_prediv4, fb_int, fb_den})
        |-> $past(sda_oe_n) == 1'b0) else $error("setting changed without a write");
    cover property (pll_soft_reset);
    cover property ($changed(fb_num));
    cover property ($changed(out_div_ratio));
endmodule : pll_ctl_chk
bind pll_status_reset_tuning pll_ctl_chk u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .pll_unlocked(pll_unlocked), .pll_cal_active(pll_cal_active),
    .pll_soft_reset(pll_soft_reset), .out_div_ratio(out_div_ratio), .out_div_tick(out_div_tick),
    .ref_prediv4(ref_prediv4), .ref_doubler(ref_doubler), .fb_int(fb_int), .fb_num(fb_num), .fb_den(fb_den)
);
`default_nettype wire

// ===== verification/serial_host_model.sv
// Behavioural host on the two-wire control bus, moving the lines on clock edges.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h58
) (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl_line,
    output logic host_oe_n
);
    // SDA idles released, so the pull-up holds it high; SCL idles driven high.
    initial begin
        scl_line = 1'b1;
        host_oe_n = 1'b1;
    end
    // Data moves two clocks into the low phase, after the target has let go of its bit.
    task automatic bit_slot(input logic b, output logic seen);
        repeat (2) @(posedge clk_sys);
        host_oe_n <= b;
        repeat (2) @(posedge clk_sys);
        scl_line <= 1'b1;
        repeat (3) @(posedge clk_sys);
        seen = sda_line;
        @(posedge clk_sys);
        scl_line <= 1'b0;
    endtask : bit_slot
    task automatic start();
        repeat (4) @(posedge clk_sys);
        host_oe_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        scl_line <= 1'b0;
    endtask : start
    task automatic stop();
        repeat (2) @(posedge clk_sys);
        host_oe_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        scl_line <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host_oe_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = !s;
    endtask : send_byte
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(nack, s);
    endtask : recv_byte
    // All bytes go in one transaction, so a paired register commits whole.
    task automatic write_regs(input logic [7:0] ofs, input int n, input logic [7:0] b0, b1, b2, output logic ack);
        logic [7:0] b [3];
        logic a;
        b = '{b0, b1, b2};
        start();
        send_byte({DEV_ADDR, 1'b0}, ack);
        send_byte(ofs, a);
        for (int i = 0; i < n; i++) send_byte(b[i], a);
        stop();
    endtask : write_regs
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        start();
        send_byte({DEV_ADDR, 1'b0}, a);
        send_byte(ofs, a);
        stop();
        start();
        send_byte({DEV_ADDR, 1'b1}, a);
        recv_byte(1'b1, d);
        stop();
    endtask : read_reg
    task automatic probe(input logic [6:0] addr, output logic ack);
        start();
        send_byte({addr, 1'b0}, ack);
        stop();
    endtask : probe
    // Tuning rewrites only the numerator bytes, never the integer byte.
    task automatic tune(input logic [21:0] num);
        logic a;
        write_regs(8'h24, 3, {2'b00, num[21:16]}, num[15:8], num[7:0], a);
    endtask : tune
endmodule : serial_host_model
`default_nettype wire

// ===== verification/test_pll_status_reset_tuning.sv
// Self-checking bench for the PLL control and status slice.
`timescale 1ns/1ps
`default_nettype none
module test_pll_status_reset_tuning;
    localparam logic [6:0] BUS_ADDR = 7'h58; // Arbitrary bus address.
    typedef struct {
        logic [7:0] ofs;
        int n;
        logic [7:0] b0, b1;
        logic [8:0] div;
        logic [1:0] refs;
        logic [7:0] fbi;
    } row_t;
    logic clk_sys, rst_n, pll_unlocked, pll_cal_active, scl_line, host_oe_n, sda_line, sda_out, sda_oe_n;
    logic pll_soft_reset, out_div_tick, ref_prediv4, ref_doubler, ack;
    logic [8:0] out_div_ratio;
    logic [7:0] fb_int, rd;
    logic [21:0] fb_num, fb_den;
    int err_total = 0;
    int num_checks = 0;
    int pulses = 0;
    int since = -1;
    int first_gap = 0;
    row_t rows [10];
    // Open-drain data line with a pull-up: low when either side pulls.
    assign sda_line = host_oe_n & (sda_oe_n | sda_out);
    pll_status_reset_tuning #(.DEV_ADDR(BUS_ADDR)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .pll_unlocked(pll_unlocked), .pll_cal_active(pll_cal_active),
        .pll_soft_reset(pll_soft_reset), .out_div_ratio(out_div_ratio), .out_div_tick(out_div_tick),
        .ref_prediv4(ref_prediv4), .ref_doubler(ref_doubler), .fb_int(fb_int), .fb_num(fb_num), .fb_den(fb_den)
    );
    serial_host_model #(.DEV_ADDR(BUS_ADDR)) host (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl_line(scl_line), .host_oe_n(host_oe_n)
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Pulses and the first divider tick after one are timed on the falling edge, clear of updates.
    always @(negedge clk_sys) begin
        if (pll_soft_reset === 1'b1) begin
            pulses++;
            since = 0;
        end else if (since >= 0) begin
            since++;
            if (out_div_tick === 1'b1) begin
                first_gap = since;
                since = -1;
            end
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // The whole sequence needs about 7700 clocks; a hang stops well past that.
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        pll_unlocked = 1'b0;
        pll_cal_active = 1'b0;
        // Ratio 76 with integer 220 keeps the oscillator in band.
        rows = '{'{8'h22, 1, 8'h01, 8'h00, 9'h04c, 2'b01, 8'hdc}, '{8'h22, 1, 8'h02, 8'h00, 9'h04c, 2'b10, 8'hdc},
            '{8'h22, 1, 8'h03, 8'h00, 9'h04c, 2'b11, 8'hdc}, '{8'h23, 1, 8'hdd, 8'h00, 9'h04c, 2'b11, 8'hdd},
            '{8'h20, 2, 8'h05, 8'h00, 9'h005, 2'b11, 8'hdd}, '{8'h20, 2, 8'hff, 8'h01, 9'h1ff, 2'b11, 8'hdd},
            '{8'h20, 2, 8'h04, 8'h00, 9'h1ff, 2'b11, 8'hdd}, '{8'h20, 2, 8'h4c, 8'h00, 9'h04c, 2'b11, 8'hdd},
            '{8'h22, 1, 8'h00, 8'h00, 9'h04c, 2'b00, 8'hdd}, '{8'h23, 1, 8'hdc, 8'h00, 9'h04c, 2'b00, 8'hdc}};
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(out_div_ratio, 9'h04c);
        chk({ref_doubler, ref_prediv4}, 2'b00);
        chk(fb_num, 22'h00_0000);
        foreach (rows[i]) begin
            host.write_regs(rows[i].ofs, rows[i].n, rows[i].b0, rows[i].b1, 8'h00, ack);
            chk(out_div_ratio, rows[i].div);
            chk({ref_doubler, ref_prediv4}, rows[i].refs);
            chk(fb_int, rows[i].fbi);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            pll_unlocked <= k[1];
            pll_cal_active <= k[0];
            host.read_reg(8'h42, rd);
            chk(rd, k[1:0]);
        end
        host.write_regs(8'h48, 1, 8'h01, 8'h00, 8'h00, ack);
        chk(pulses, 0);
        host.write_regs(8'h48, 1, 8'hff, 8'h00, 8'h00, ack);
        host.read_reg(8'h48, rd);
        chk(rd, 8'h00);
        chk(pulses, 1);
        chk(first_gap, 77);
        host.write_regs(8'h27, 3, 8'h00, 8'h10, 8'h00, ack);
        chk(fb_den, 22'h00_1000);
        host.tune(22'h00_0800);
        chk(fb_num, 22'h00_0800);
        chk(fb_int, 8'hdc);
        host.tune(22'h00_1001);
        chk(fb_num, 22'h00_0800);
        host.tune(22'h00_1000);
        chk(fb_num, 22'h00_1000);
        // Read back the middle denominator byte and the low divider byte over the bus.
        host.read_reg(8'h28, rd);
        chk(rd, 8'h10);
        host.read_reg(8'h20, rd);
        chk(rd, 8'h4c);
        host.read_reg(8'h30, rd);
        chk(rd, 8'h00);
        host.probe(7'h21, ack);
        chk(ack, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        pll_unlocked <= 1'b0;
        pll_cal_active <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(fb_num, 22'h00_0000);
        chk(fb_den, 22'h3f_ffff);
        chk(fb_int, 8'hdc);
        host.read_reg(8'h42, rd);
        chk(rd, 8'h00);
        end_sim();
    end
endmodule : test_pll_status_reset_tuning
`default_nettype wire
